// ### rtl/qrp_top.sv
`timescale 1ns/1ps
module qrp_top
    import qrp_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // pipeline pins
    input  wire logic                  instr_bit0,
    input  wire logic                  instr_bit1,
    input  wire logic                  sel_bit0,
    input  wire logic                  sel_bit1,
    input  wire logic [QRP_DATA_W-1:0] data_in,
    input  wire logic                  out_en_b,
    output logic [QRP_DATA_W-1:0]      data_out,
    output logic                       data_out_oe,
    output logic                       pin_ready,
    // register port
    input  wire logic [QRP_ADDR_W-1:0] reg_addr,
    input  wire logic [QRP_BUS_W-1:0]  reg_wr_data,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [QRP_BUS_W-1:0]       reg_rd_data
);

    // select code LL reads the last stage, HH the first
    function automatic logic [1:0] qrp_sel_idx(input logic [1:0] sel);
        return ~sel;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    localparam int PIN_W = QRP_DATA_W + 5;
    // syncs wake at pin idle: enable off, hold code, so no stray shift
    localparam logic [PIN_W-1:0] PIN_IDLE = {1'b1, 2'h0, QRP_OP_HOLD, 16'h0000};

    logic [PIN_W-1:0]      pin_sync;
    logic [1:0]            instr_s;
    logic [1:0]            sel_s;
    logic [QRP_DATA_W-1:0] data_s;
    logic                  out_en_b_s;

    qrp_sync #(
        .W       (PIN_W),
        .RST_VAL (PIN_IDLE)
    ) u_pin_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .raw_in   ({out_en_b, sel_bit1, sel_bit0, instr_bit1, instr_bit0, data_in}),
        .sync_out (pin_sync)
    );

    // code and data cross together so they stay paired
    // paired code and data
    assign data_s     = pin_sync[QRP_DATA_W-1:0];
    assign instr_s    = pin_sync[QRP_DATA_W+1:QRP_DATA_W];
    assign sel_s      = pin_sync[QRP_DATA_W+3:QRP_DATA_W+2];
    assign out_en_b_s = pin_sync[QRP_DATA_W+4];

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    logic [1:0] ctrl_ff;
    wire        variant_hold = ctrl_ff[QRP_CTRL_VARIANT_BIT];
    wire        run          = ctrl_ff[QRP_CTRL_RUN_BIT];

    wire wr_ctrl = reg_wr && (reg_addr == QRP_ADDR_CTRL);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_ff <= QRP_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= reg_wr_data[1:0];
        end
    end

    // ------------------------------------------------------------------
    // instruction fifo
    // ------------------------------------------------------------------
    // clearing run stalls the drain, so the fifo fills and pin_ready drops
    logic                   fifo_in_ready;
    logic                   fifo_out_valid;
    logic [QRP_WORD_W-1:0]  fifo_word;
    logic [QRP_LEVEL_W-1:0] fifo_level;

    qrp_fifo #(
        .W     (QRP_WORD_W),
        .DEPTH (QRP_FIFO_DEP)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (1'b1),
        .in_ready  (fifo_in_ready),
        .in_data   ({instr_s, data_s}),
        .out_valid (fifo_out_valid),
        .out_ready (run),
        .out_data  (fifo_word),
        .level     (fifo_level)
    );

    wire                  pop = fifo_out_valid && run;
    wire [1:0]            op  = fifo_word[QRP_WORD_W-1:QRP_DATA_W];
    wire [QRP_DATA_W-1:0] din = fifo_word[QRP_DATA_W-1:0];

    // ------------------------------------------------------------------
    // stage update decode
    // ------------------------------------------------------------------
    logic [QRP_DATA_W-1:0] stage_ff  [QRP_STAGES];
    logic [QRP_DATA_W-1:0] nxt_stage [QRP_STAGES];

    wire op_all  = (op == QRP_OP_SHIFT_ALL);
    wire op_low  = (op == QRP_OP_LOAD_LOW);
    wire op_high = (op == QRP_OP_LOAD_HIGH);

    wire upd_one   = pop && (op_all || op_high);
    wire upd_three = pop && (op_all || op_low);
    wire upd_two   = pop && (op_all || (op_high && !variant_hold));
    wire upd_four  = pop && (op_all || (op_low && !variant_hold));

    assign nxt_stage[0] = upd_one   ? din         : stage_ff[0];
    assign nxt_stage[1] = upd_two   ? stage_ff[0] : stage_ff[1];
    assign nxt_stage[2] = upd_three ? (op_all ? stage_ff[1] : din) : stage_ff[2];
    assign nxt_stage[3] = upd_four  ? stage_ff[2] : stage_ff[3];
    // hold code falls through every select above

    genvar g;
    generate
        for (g = 0; g < QRP_STAGES; g++) begin : g_stage
            always_ff @(posedge clk) begin
                stage_ff[g] <= nxt_stage[g];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // output path
    // ------------------------------------------------------------------
    // select ignores instruction
    wire [1:0]            out_idx  = qrp_sel_idx(sel_s);
    wire [QRP_DATA_W-1:0] out_pick = nxt_stage[out_idx];

    logic [QRP_DATA_W-1:0] data_out_ff;
    logic                  oe_ff;
    logic                  pin_ready_ff;

    // muxing nxt values lets the output show the new stage right after the edge
    // output follows update
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            data_out_ff  <= '0;
            oe_ff        <= 1'b0;
            pin_ready_ff <= 1'b0;
        end else begin
            data_out_ff  <= out_pick;
            oe_ff        <= !out_en_b_s;
            pin_ready_ff <= fifo_in_ready;
        end
    end

    assign data_out    = data_out_ff;
    assign data_out_oe = oe_ff;
    assign pin_ready   = pin_ready_ff;

    // ------------------------------------------------------------------
    // register read path
    // ------------------------------------------------------------------
    wire        rd_stage = (reg_addr >= QRP_ADDR_STAGE1) && (reg_addr <= QRP_ADDR_STAGE4);
    wire [1:0]  rd_idx   = 2'(reg_addr[4:2] - QRP_ADDR_STAGE1[4:2]);

    wire [QRP_BUS_W-1:0] status_word =
        (QRP_BUS_W'(fifo_level) << QRP_STAT_LEVEL_LSB) |
        (QRP_BUS_W'(!fifo_out_valid) << QRP_STAT_EMPTY_BIT) |
        (QRP_BUS_W'(!fifo_in_ready) << QRP_STAT_FULL_BIT);

    // unmapped addresses read as zero
    wire [QRP_BUS_W-1:0] rd_mux =
        (reg_addr == QRP_ADDR_CTRL)   ? QRP_BUS_W'(ctrl_ff) :
        (reg_addr == QRP_ADDR_STATUS) ? status_word :
        rd_stage                      ? QRP_BUS_W'(stage_ff[rd_idx]) :
                                        '0;

    logic [QRP_BUS_W-1:0] rd_data_ff;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= reg_rd ? rd_mux : '0;
        end
    end

    assign reg_rd_data = rd_data_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_pop_op(logic [1:0] code);
        pop && (op == code);
    endsequence

    sequence s_partial(logic [1:0] code, logic var_hold);
        pop && (op == code) && (variant_hold == var_hold);
    endsequence

    a_shift_chain: assert property (
        s_pop_op(QRP_OP_SHIFT_ALL) |=>
            stage_ff[0] === $past(din) && stage_ff[1] === $past(stage_ff[0]) &&
            stage_ff[2] === $past(stage_ff[1]) && stage_ff[3] === $past(stage_ff[2]))
        else $error("full shift did not move the chain");

    a_hold_all: assert property (
        s_pop_op(QRP_OP_HOLD) |=>
            $stable(stage_ff[0]) && $stable(stage_ff[1]) &&
            $stable(stage_ff[2]) && $stable(stage_ff[3]))
        else $error("hold code changed a stage");

    a_low_shift: assert property (
        s_partial(QRP_OP_LOAD_LOW, 1'b0) |=>
            stage_ff[2] == $past(din) && stage_ff[3] == $past(stage_ff[2]) &&
            $stable(stage_ff[0]) && $stable(stage_ff[1]))
        else $error("low load in shifting variant wrong");

    a_high_shift: assert property (
        s_partial(QRP_OP_LOAD_HIGH, 1'b0) |=>
            stage_ff[0] == $past(din) && stage_ff[1] == $past(stage_ff[0]) &&
            $stable(stage_ff[2]) && $stable(stage_ff[3]))
        else $error("high load in shifting variant wrong");

    a_low_only: assert property (
        s_partial(QRP_OP_LOAD_LOW, 1'b1) |=>
            stage_ff[2] == $past(din) && $stable(stage_ff[3]) &&
            $stable(stage_ff[0]) && $stable(stage_ff[1]))
        else $error("low load in holding variant wrong");

    a_high_only: assert property (
        s_partial(QRP_OP_LOAD_HIGH, 1'b1) |=>
            stage_ff[0] == $past(din) && $stable(stage_ff[1]) &&
            $stable(stage_ff[2]) && $stable(stage_ff[3]))
        else $error("high load in holding variant wrong");

    a_idle_keeps: assert property (
        !pop |=> $stable(stage_ff[0]) && $stable(stage_ff[3]))
        else $error("stage changed without an instruction");

    a_out_select: assert property (
        1'b1 |=> data_out === stage_ff[qrp_sel_idx($past(sel_s))])
        else $error("output does not show the selected stage");

    a_sel_first: assert property (
        sel_s == 2'h3 |=> data_out === $past(nxt_stage[0]))
        else $error("select code three did not pick stage one");

    a_sel_last: assert property (
        sel_s == 2'h0 |=> data_out === $past(nxt_stage[3]))
        else $error("select code zero did not pick stage four");

    a_oe_on: assert property (
        !out_en_b_s |=> data_out_oe)
        else $error("output not driven while enabled");

    // stalled drain must leave stages two and three alone
    a_stall_keeps: assert property (
        !run |=> $stable(stage_ff[1]) && $stable(stage_ff[2]))
        else $error("stage changed while drain stalled");

    a_ready_room: assert property (
        fifo_in_ready |=> pin_ready)
        else $error("ready low although fifo has room");

    a_ready_full: assert property (
        !fifo_in_ready |=> !pin_ready)
        else $error("ready high although fifo full");

    a_level_max: assert property (
        fifo_level <= QRP_LEVEL_W'(QRP_FIFO_DEP))
        else $error("fifo level above depth");

    a_full_refuse: assert property (
        !fifo_in_ready && !pop |=> fifo_level == QRP_LEVEL_W'(QRP_FIFO_DEP))
        else $error("full fifo took a word");

    a_empty_flag: assert property (
        fifo_out_valid == (fifo_level != '0))
        else $error("fifo valid disagrees with level");

    a_ctrl_write: assert property (
        wr_ctrl |=> ctrl_ff == $past(reg_wr_data[1:0]))
        else $error("control write lost");

    a_ro_ignore: assert property (
        reg_wr && (reg_addr != QRP_ADDR_CTRL) |=> $stable(ctrl_ff))
        else $error("write elsewhere changed control");

    a_ctrl_read: assert property (
        reg_rd && (reg_addr == QRP_ADDR_CTRL) |=> reg_rd_data == QRP_BUS_W'($past(ctrl_ff)))
        else $error("control readback wrong");

    a_status_read: assert property (
        reg_rd && (reg_addr == QRP_ADDR_STATUS) |=> reg_rd_data == $past(status_word))
        else $error("status readback wrong");

    // read data must not linger past its one cycle
    a_rd_idle: assert property (
        !reg_rd |=> reg_rd_data == '0)
        else $error("read data stood without a strobe");

    a_oe_follow: assert property (
        $fell(out_en_b_s) |=> data_out_oe ##1 1'b1)
        else $error("output enable did not follow pin");

    a_oe_off: assert property (
        out_en_b_s [*2] |=> !data_out_oe)
        else $error("output driven while disabled");

    a_rd_latency: assert property (
        reg_rd && rd_stage |=> reg_rd_data == QRP_BUS_W'($past(stage_ff[rd_idx])))
        else $error("stage readback wrong");

endmodule

// ### rtl/qrp_pkg.sv
package qrp_pkg;

    // datapath geometry
    localparam int QRP_DATA_W   = 16;
    localparam int QRP_STAGES   = 4;
    localparam int QRP_FIFO_DEP = 16;
    localparam int QRP_WORD_W   = QRP_DATA_W + 2;
    localparam int QRP_LEVEL_W  = 5;

    // register bus geometry
    localparam int QRP_ADDR_W   = 5;
    localparam int QRP_BUS_W    = 32;

    // instruction codes, {instr_bit1, instr_bit0}
    localparam logic [1:0] QRP_OP_SHIFT_ALL = 2'h0;
    localparam logic [1:0] QRP_OP_LOAD_LOW  = 2'h1;
    localparam logic [1:0] QRP_OP_LOAD_HIGH = 2'h2;
    localparam logic [1:0] QRP_OP_HOLD      = 2'h3;

    // register offsets (byte addresses)
    localparam logic [4:0] QRP_ADDR_CTRL    = 5'h00;
    localparam logic [4:0] QRP_ADDR_STATUS  = 5'h04;
    localparam logic [4:0] QRP_ADDR_STAGE1  = 5'h08;
    localparam logic [4:0] QRP_ADDR_STAGE4  = 5'h14;

    // control fields and reset value
    localparam int         QRP_CTRL_VARIANT_BIT = 0;
    localparam int         QRP_CTRL_RUN_BIT     = 1;
    localparam logic [1:0] QRP_CTRL_RST         = 2'h2;

    // status fields
    localparam int QRP_STAT_LEVEL_LSB = 0;
    localparam int QRP_STAT_EMPTY_BIT = 8;
    localparam int QRP_STAT_FULL_BIT  = 9;

endpackage

// ### rtl/qrp_sync.sv
`timescale 1ns/1ps
module qrp_sync #(
    parameter int             W       = 1,
    // idle level of each pin, so release shows no false code or edge
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // raw and synchronised levels
    input  wire logic [W-1:0] raw_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= raw_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// ### rtl/qrp_fifo.sv
`timescale 1ns/1ps
module qrp_fifo #(
    parameter int W     = 18,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    // fill side
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [W-1:0]               in_data,
    // drain side
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [W-1:0]                    out_data,
    // occupancy
    output logic [$clog2(DEPTH+1)-1:0]      level
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [W-1:0]  mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;

    wire do_push = in_valid && in_ready;
    wire do_pop  = out_valid && out_ready;

    assign in_ready  = (count_ff != CW'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign level     = count_ff;

    // storage needs no reset, pointers guard it
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            wr_ptr_ff <= do_push ? PW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
            rd_ptr_ff <= do_pop ? PW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
            count_ff  <= CW'(count_ff + CW'(do_push) - CW'(do_pop));
        end
    end

endmodule

// ### dv/qrp_src_model.sv
`timescale 1ns/1ps
module qrp_src_model
    import qrp_pkg::*;
(
    // clock
    input  wire logic             clk,
    // pins toward the pipeline
    output logic                  instr_bit0,
    output logic                  instr_bit1,
    output logic                  sel_bit0,
    output logic                  sel_bit1,
    output logic [QRP_DATA_W-1:0] data_in,
    output logic                  out_en_b
);
    initial begin
        {instr_bit1, instr_bit0} = QRP_OP_HOLD;
        {sel_bit1, sel_bit0} = 2'h0;
        data_in = 16'h0000;
        out_en_b = 1'b1;
    end
    task automatic send(input logic [1:0] code, input logic [QRP_DATA_W-1:0] d);
        @(posedge clk);
        {instr_bit1, instr_bit0} <= code;
        data_in <= d;
    endtask
    // idle is hold; data flips so a stale word never looks valid
    task automatic idle();
        @(posedge clk);
        {instr_bit1, instr_bit0} <= QRP_OP_HOLD;
        data_in <= ~data_in;
    endtask
    task automatic view(input logic [1:0] sel, input logic oe_b);
        @(posedge clk);
        {sel_bit1, sel_bit0} <= sel;
        out_en_b <= oe_b;
    endtask
endmodule

// ### dv/quad_register_pipeline_16_bench.sv
`timescale 1ns/1ps
module quad_register_pipeline_16_bench;
    import qrp_pkg::*;
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    logic                  instr_bit0, instr_bit1, sel_bit0, sel_bit1, out_en_b;
    logic [QRP_DATA_W-1:0] data_in, data_out;
    logic                  data_out_oe, pin_ready;
    logic [QRP_ADDR_W-1:0] reg_addr = 5'h00;
    logic [QRP_BUS_W-1:0]  reg_wr_data = 32'h0, reg_rd_data, rd_q;
    logic                  reg_wr = 1'b0, reg_rd = 1'b0, variant = 1'b0;
    wire  [QRP_DATA_W-1:0] data_bus;
    logic [QRP_DATA_W-1:0] exp_q [1:4];
    int                    n_mismatch = 0, total_checks = 0;

    always #2.5 clk = ~clk;
    assign data_bus = data_out_oe ? data_out : 16'hzzzz;

    qrp_top dut_u (.clk(clk), .rst_b(rst_b), .instr_bit0(instr_bit0), .instr_bit1(instr_bit1),
        .sel_bit0(sel_bit0), .sel_bit1(sel_bit1), .data_in(data_in), .out_en_b(out_en_b),
        .data_out(data_out), .data_out_oe(data_out_oe), .pin_ready(pin_ready),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data));
    qrp_src_model src_u (.clk(clk), .instr_bit0(instr_bit0), .instr_bit1(instr_bit1),
        .sel_bit0(sel_bit0), .sel_bit1(sel_bit1), .data_in(data_in), .out_en_b(out_en_b));

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        total_checks++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rd_data;
    endtask
    function automatic void apply(input logic [1:0] code, input logic [15:0] d);
        case (code)
            QRP_OP_SHIFT_ALL: begin
                exp_q[4] = exp_q[3];
                exp_q[3] = exp_q[2];
                exp_q[2] = exp_q[1];
                exp_q[1] = d;
            end
            QRP_OP_LOAD_LOW: begin
                if (!variant) exp_q[4] = exp_q[3];
                exp_q[3] = d;
            end
            QRP_OP_LOAD_HIGH: begin
                if (!variant) exp_q[2] = exp_q[1];
                exp_q[1] = d;
            end
            default: ;
        endcase
    endfunction
    task automatic push(input logic [1:0] code, input logic [15:0] d);
        src_u.send(code, d);
        apply(code, d);
    endtask
    // pin-to-stage latency is four edges with the fifo empty
    task automatic settle();
        src_u.idle();
        repeat (6) @(posedge clk);
    endtask
    task automatic check_stages();
        for (int i = 0; i < 4; i++) begin
            reg_read(QRP_ADDR_STAGE1 + 5'(4 * i), rd_q);
            check(rd_q, {16'h0, exp_q[i + 1]});
        end
    endtask

    task automatic t_reset();
        #1 check(data_out_oe, 1'b0);
        reg_read(QRP_ADDR_CTRL, rd_q);
        check(rd_q, {30'h0, QRP_CTRL_RST});
    endtask
    task automatic t_shift_all();
        push(QRP_OP_SHIFT_ALL, 16'h1234);
        push(QRP_OP_SHIFT_ALL, 16'hffff);
        push(QRP_OP_SHIFT_ALL, 16'h0001);
        push(QRP_OP_SHIFT_ALL, 16'h8000);
        settle();
        check_stages();
    endtask
    task automatic t_select();
        for (int s = 0; s < 4; s++) begin
            src_u.view(2'(s), 1'b0);
            repeat (5) @(posedge clk);
            #1 check(data_bus, exp_q[4 - s]);
        end
        src_u.view(2'h0, 1'b1);
        repeat (5) @(posedge clk);
        #1 check(data_out_oe, 1'b0);
        check(data_bus, 16'hzzzz);
    endtask
    task automatic t_partial(input logic v);
        reg_write(QRP_ADDR_CTRL, {30'h0, 1'b1, v});
        variant = v;
        push(QRP_OP_LOAD_LOW, 16'ha5a5);
        push(QRP_OP_LOAD_HIGH, 16'h5a5a);
        push(QRP_OP_HOLD, 16'hdead);
        settle();
        check_stages();
    endtask
    task automatic t_indep();
        logic [15:0] kept;
        src_u.view(2'h0, 1'b0);
        repeat (5) @(posedge clk);
        kept = exp_q[4];
        push(QRP_OP_LOAD_HIGH, 16'h0f0f);
        src_u.idle();
        repeat (6) begin
            @(posedge clk);
            #1 check(data_out, kept);
        end
        src_u.view(2'h3, 1'b0);
        repeat (5) @(posedge clk);
        #1 check(data_out, 16'h0f0f);
    endtask
    // run off lets the fifo fill from the ever-valid pin samples
    task automatic t_fifo();
        reg_write(QRP_ADDR_CTRL, 32'h0);
        repeat (24) @(posedge clk);
        #1 check(pin_ready, 1'b0);
        reg_read(QRP_ADDR_STATUS, rd_q);
        check({rd_q[QRP_STAT_FULL_BIT], rd_q[4:0]}, {1'b1, 5'(QRP_FIFO_DEP)});
        reg_write(QRP_ADDR_CTRL, {30'h0, QRP_CTRL_RST});
        variant = 1'b0;
        repeat (24) @(posedge clk);
        #1 check(pin_ready, 1'b1);
        reg_read(QRP_ADDR_STATUS, rd_q);
        check(rd_q[QRP_STAT_FULL_BIT], 1'b0);
        check_stages();
    endtask
    task automatic t_regs();
        reg_read(5'h1c, rd_q);
        check(rd_q, 32'h0);
        reg_write(QRP_ADDR_STAGE1, 32'h0000_beef);
        reg_read(QRP_ADDR_STAGE1, rd_q);
        check(rd_q, {16'h0, exp_q[1]});
        @(posedge clk);
        #1 check(reg_rd_data, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_shift_all();
        t_select();
        t_partial(1'b0);
        t_partial(1'b1);
        t_indep();
        t_fifo();
        t_regs();
        print_verdict();
    end
    initial begin
        #20us;
        n_mismatch++;
        print_verdict();
    end
endmodule
